// File: logic/bpcl_bus_if.sv
// Interface: decoded bus cycle between the cycle decoder and the port core
`timescale 1ns/10ps
interface bpcl_bus_if;
  logic rd_go;
  logic wr_go;
  modport dec (output rd_go, output wr_go);
  modport core (input rd_go, input wr_go);
endinterface

// File: logic/bpcl_cycle.sv
// Cycle decoder: turns synchronised strobes into one-cycle read and write starts
`timescale 1ns/10ps
module bpcl_cycle
  import bpcl_pkg::*;
(
  input wire logic i_clk_sys, // System clock
  input wire logic i_rst,     // Synchronous reset
  input wire logic i_sel,     // Request and select both active
  input wire logic i_rd,      // Read active
  bpcl_bus_if.dec bus         // Decoded cycle starts
);
  bpcl_cyc_e st_q, st_d;
  logic rd_go_q, rd_go_d, wr_go_q, wr_go_d;

  always_comb
  begin
    st_d = st_q;
    rd_go_d = 1'b0;
    wr_go_d = 1'b0;
    case (st_q)
      BPCL_IDLE:
      begin
        if (i_sel && i_rd)
        begin
          st_d = BPCL_HOLD;
          rd_go_d = 1'b1;
        end
        else if (i_sel)
        begin
          st_d = BPCL_HOLD;
          wr_go_d = 1'b1;
        end
      end
      BPCL_HOLD:
      begin
        // One action per bus cycle however long the strobes stay low
        if (!i_sel)
          st_d = BPCL_IDLE;
      end
      default:
        st_d = BPCL_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      st_q <= BPCL_IDLE;
      rd_go_q <= 1'b0;
      wr_go_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      rd_go_q <= rd_go_d;
      wr_go_q <= wr_go_d;
    end
  end

  assign bus.rd_go = rd_go_q;
  assign bus.wr_go = wr_go_q;
endmodule

// File: logic/bpcl_pkg.sv
// Package: constants for the bit port and command logic
package bpcl_pkg;
  localparam int BPCL_WIDTH = 8;
  localparam logic [7:0] BPCL_DIR_RST = 8'hff;        // All bits inputs after reset
  localparam logic [7:0] BPCL_LATCH_RST = 8'h00;
  localparam logic [2:0] BPCL_CHAIN_RST = 3'h0;
  localparam int BPCL_CHAIN_LSB = 0;
  localparam int BPCL_CHAIN_FLAG_BIT = 3;
  localparam int BPCL_RST_SERIAL_BIT = 4;
  localparam int BPCL_RST_TIMER_BIT = 5;
  localparam int BPCL_RST_PARALLEL_BIT = 6;
  localparam int BPCL_ROUTE_BIT = 7;
  localparam int BPCL_TR_A_BIT = 5;
  localparam int BPCL_TR_B_BIT = 2;
  localparam logic [1:0] BPCL_SEL_DATA = 2'h0;
  localparam logic [1:0] BPCL_SEL_DIR = 2'h1;
  localparam logic [1:0] BPCL_SEL_CMD = 2'h2;
  localparam int BPCL_RST_MIN_CYC = 3;
  typedef enum logic [1:0]
  {
    BPCL_IDLE = 2'b00,
    BPCL_READ = 2'b01,
    BPCL_WRITE = 2'b10,
    BPCL_HOLD = 2'b11
  } bpcl_cyc_e;
endpackage

// File: logic/bpcl_top.sv
// Top: bit-programmable port with command register
`timescale 1ns/10ps
module bpcl_top
  import bpcl_pkg::*;
#(
  parameter int WIDTH = BPCL_WIDTH
)
(
  input wire logic i_clk_sys,                  // 40 MHz system clock
  input wire logic i_sys_rst,                  // Synchronous reset, high
  input wire logic i_io_request_n,             // I/O request, low
  input wire logic i_cs_n,                     // Chip select, low
  input wire logic i_rd_n,                     // Read strobe, low
  input wire logic [1:0] i_reg_sel,            // Register select
  input wire logic [7:0] i_data,               // CPU data in
  output logic [7:0] o_data,                   // CPU data out
  output logic o_data_oe_n,                    // Data bus drive enable, low
  input wire logic [WIDTH-1:0] i_pin,          // Port pin levels
  output logic [WIDTH-1:0] o_pin,              // Port pin drive values
  output logic [WIDTH-1:0] o_pin_oe_n,         // Port pin enables, low drives
  input wire logic i_terminal_ready_out_a,     // Serial channel A terminal ready
  input wire logic i_terminal_ready_out_b,     // Serial channel B terminal ready
  output logic [2:0] o_chain_order,            // Daisy-chain order code
  output logic o_rst_serial_unit,              // Reset pulse to serial unit
  output logic o_rst_counter_timer_unit,       // Reset pulse to timer unit
  output logic o_rst_parallel_port_unit,       // Reset pulse to parallel unit
  output logic o_serial_signal_route_flag,     // Pins carry serial signals
  output logic o_irq_n                         // Interrupt, never asserted
);
  bpcl_bus_if bus();
  // Pins and bus strobes come from outside the clock domain
  logic [WIDTH-1:0] pin_s1_q, pin_s2_q;
  logic [2:0] ctl_s1_q, ctl_s2_q;
  logic [1:0] tr_s1_q, tr_s2_q;
  // Select and data need no handshake of their own: the synced strobes qualify them
  logic [1:0] rsel_s1_q, rsel_s2_q;
  logic [7:0] wdat_s1_q, wdat_s2_q;
  logic [WIDTH-1:0] dir_q, dir_d, latch_q, latch_d;
  logic [7:0] data_q, data_d;
  logic oe_n_q, oe_n_d;
  logic [2:0] chain_q, chain_d, urst_q, urst_d;
  logic route_q, route_d;
  logic [WIDTH-1:0] pin_q, pin_d, pin_oe_n_q, pin_oe_n_d;
  logic irq_n_q, irq_n_d;
  logic sel, rd;

  always_ff @(posedge i_clk_sys)
  begin
    pin_s1_q <= i_pin;
    pin_s2_q <= pin_s1_q;
    ctl_s1_q <= {i_io_request_n, i_cs_n, i_rd_n};
    ctl_s2_q <= ctl_s1_q;
    tr_s1_q <= {i_terminal_ready_out_a, i_terminal_ready_out_b};
    tr_s2_q <= tr_s1_q;
    // Select and data pass the same two stages as the strobes, so they arrive in step with them
    rsel_s1_q <= i_reg_sel;
    rsel_s2_q <= rsel_s1_q;
    wdat_s1_q <= i_data;
    wdat_s2_q <= wdat_s1_q;
  end

  assign sel = !ctl_s2_q[2] && !ctl_s2_q[1];
  assign rd = !ctl_s2_q[0];

  bpcl_cycle u_cycle
  (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_sys_rst),
    .i_sel(sel),
    .i_rd(rd),
    .bus(bus.dec)
  );

  // Read-back mixes latch for outputs and pins for inputs
  function automatic logic [WIDTH-1:0] mix(input logic [WIDTH-1:0] dir, input logic [WIDTH-1:0] lat,
                                           input logic [WIDTH-1:0] pin);
    mix = (dir & pin) | (~dir & lat);
  endfunction

  // Bus answer: read data and its drive enable
  always_comb
  begin
    data_d = data_q;
    oe_n_d = oe_n_q;
    // Release the bus as soon as the synced read strobes drop
    if (!(sel && rd))
      oe_n_d = 1'b1;
    if (bus.rd_go)
    begin
      // Data on the bus from the edge after the capture
      oe_n_d = 1'b0;
      case (rsel_s2_q)
        BPCL_SEL_DATA: data_d = 8'(mix(dir_q, latch_q, pin_s2_q));
        BPCL_SEL_DIR: data_d = 8'(dir_q);
        BPCL_SEL_CMD: data_d = {route_q, 4'h0, chain_q};
        default: data_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      data_q <= 8'h00;
      oe_n_q <= 1'b1;
    end
    else
    begin
      data_q <= data_d;
      oe_n_q <= oe_n_d;
    end
  end

  // Control registers: direction, output latches and command
  always_comb
  begin
    dir_d = dir_q;
    latch_d = latch_q;
    chain_d = chain_q;
    route_d = route_q;
    urst_d = 3'h0;
    if (bus.wr_go)
    begin
      case (rsel_s2_q)
        BPCL_SEL_DATA: latch_d = wdat_s2_q[WIDTH-1:0];
        BPCL_SEL_DIR: dir_d = wdat_s2_q[WIDTH-1:0];
        BPCL_SEL_CMD:
        begin
          // Order and unit resets share one write, so the flag picks which one acts
          if (wdat_s2_q[BPCL_CHAIN_FLAG_BIT])
            chain_d = wdat_s2_q[BPCL_CHAIN_LSB +: 3];
          else
            urst_d = {wdat_s2_q[BPCL_RST_PARALLEL_BIT], wdat_s2_q[BPCL_RST_TIMER_BIT],
                      wdat_s2_q[BPCL_RST_SERIAL_BIT]};
          route_d = wdat_s2_q[BPCL_ROUTE_BIT];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      dir_q <= WIDTH'(BPCL_DIR_RST);
      latch_q <= WIDTH'(BPCL_LATCH_RST);
      chain_q <= BPCL_CHAIN_RST;
      route_q <= 1'b0;
      urst_q <= 3'h0;
    end
    else
    begin
      dir_q <= dir_d;
      latch_q <= latch_d;
      chain_q <= chain_d;
      route_q <= route_d;
      urst_q <= urst_d;
    end
  end

  always_comb
  begin
    pin_d = latch_q;
    pin_oe_n_d = dir_q; // Direction bit one means input, so not driven
    // No interrupt source here; still a flop like every other output
    irq_n_d = 1'b1;
    if (route_q)
    begin
      // Serial signals take bits 5 and 2 as driven outputs
      pin_d[BPCL_TR_A_BIT] = tr_s2_q[1];
      pin_d[BPCL_TR_B_BIT] = tr_s2_q[0];
      pin_oe_n_d[BPCL_TR_A_BIT] = 1'b0;
      pin_oe_n_d[BPCL_TR_B_BIT] = 1'b0;
    end
  end

  // Pin drive leaves flops so the pads never see decode glitches
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      pin_q <= '0;
      pin_oe_n_q <= '1;
      irq_n_q <= 1'b1;
    end
    else
    begin
      pin_q <= pin_d;
      pin_oe_n_q <= pin_oe_n_d;
      irq_n_q <= irq_n_d;
    end
  end

  assign o_data = data_q;
  assign o_data_oe_n = oe_n_q;
  assign o_pin = pin_q;
  assign o_pin_oe_n = pin_oe_n_q;
  assign o_chain_order = chain_q;
  assign o_rst_serial_unit = urst_q[0];
  assign o_rst_counter_timer_unit = urst_q[1];
  assign o_rst_parallel_port_unit = urst_q[2];
  assign o_serial_signal_route_flag = route_q;
  assign o_irq_n = irq_n_q;
endmodule

// File: verif/bpcl_pin_model.sv
// Pin model: resolves port pin levels from the port and an outside source
`timescale 1ns/10ps
module bpcl_pin_model
(
  input wire logic [7:0] i_drv, // Port drive values
  input wire logic [7:0] i_oe_n, // Port enables, low drives
  input wire logic [7:0] i_ext, // Outside levels
  output logic [7:0] o_lvl // Resolved levels
);
  // Outside source yields where the port drives, so there is no contention
  assign o_lvl = (i_drv & ~i_oe_n) | (i_ext & i_oe_n);
endmodule

// File: verif/bpcl_properties.sv
// Checker: port timing of the bit port and command logic
`timescale 1ns/10ps
module bpcl_properties #(parameter int WIDTH = 8)
(
  input wire logic i_clk_sys, // Clock
  input wire logic i_sys_rst, // Reset
  input wire logic i_io_request_n, // Request
  input wire logic i_cs_n, // Select
  input wire logic i_rd_n, // Read
  input wire logic [1:0] i_reg_sel, // Register
  input wire logic [7:0] i_data, // Write data
  input wire logic o_data_oe_n, // Bus drive
  input wire logic [WIDTH-1:0] o_pin_oe_n, // Pin drive
  input wire logic [2:0] o_chain_order, // Order
  input wire logic o_rst_serial_unit, // Reset A
  input wire logic o_rst_counter_timer_unit, // Reset B
  input wire logic o_rst_parallel_port_unit, // Reset C
  input wire logic o_serial_signal_route_flag, // Route
  input wire logic o_irq_n // Interrupt
);
  logic rdc;
  logic cw;
  logic [2:0] rs;
  assign rdc = !i_io_request_n && !i_cs_n && !i_rd_n;
  assign cw = !i_io_request_n && !i_cs_n && i_rd_n && i_reg_sel == 2'h2;
  assign rs = {o_rst_parallel_port_unit, o_rst_counter_timer_unit, o_rst_serial_unit};
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  property p_irq; o_irq_n; endproperty
  property p_rd; $rose(rdc) |-> ##4 !o_data_oe_n; endproperty
  property p_rd_off; !rdc [*5] |-> o_data_oe_n; endproperty
  property p_order; $rose(cw) && i_data[3] |-> ##4 o_chain_order == i_data[2:0]; endproperty
  property p_keep; $rose(cw) && !i_data[3] |-> $stable(o_chain_order) [*6]; endproperty
  // Pulses only without the order flag, and for a single cycle
  property p_unit; $rose(cw) |-> ##4 rs == (i_data[3] ? 3'h0 : i_data[6:4]) ##1 rs == 3'h0; endproperty
  property p_route; $rose(cw) |-> ##5 o_serial_signal_route_flag == i_data[7]; endproperty
  property p_pins; o_serial_signal_route_flag [*3] |-> !o_pin_oe_n[5] && !o_pin_oe_n[2]; endproperty
  property p_rst; $fell(i_sys_rst) |-> &o_pin_oe_n && !o_serial_signal_route_flag; endproperty
  a_irq: assert property (p_irq) else $error("interrupt asserted");
  a_rd: assert property (p_rd) else $error("read data not driven");
  a_rd_off: assert property (p_rd_off) else $error("bus driven while idle");
  a_order: assert property (p_order) else $error("order not loaded");
  a_keep: assert property (p_keep) else $error("order changed");
  a_unit: assert property (p_unit) else $error("unit reset pulse wrong");
  a_route: assert property (p_route) else $error("route flag wrong");
  a_pins: assert property (p_pins) else $error("ready pins not driven");
  a_rst: assert property (p_rst) else $error("reset state wrong");
  c_rd: cover property ($rose(rdc));
  c_unit: cover property ($rose(cw) && !i_data[3] && i_data[6:4] != 3'h0);
  c_route: cover property (o_serial_signal_route_flag);
endmodule
bind bpcl_top bpcl_properties #(.WIDTH(WIDTH)) bpcl_properties_i (.*);

// File: verif/bpcl_top_test.sv
// Testbench: bus cycles, pin levels and command register of the port
`timescale 1ns/10ps
module bpcl_top_test;
  logic clk = 0, rst = 1, io_n = 1, cs_n = 1, rd_n = 1, tra = 0, trb = 0, route, irq;
  logic doe, qoe, rs_s, rs_t, rs_p;
  logic [2:0] useen = 3'h0;
  logic [1:0] sel = 2'h0;
  logic [7:0] wd = 8'h00, ext = 8'h5a, q, lvl, dout, pin, oe_n;
  logic [2:0] chain;
  int n_errors = 0, num_checks = 0, n_pulse = 0;
  bpcl_top bpcl_top_i (.i_clk_sys(clk), .i_sys_rst(rst), .i_io_request_n(io_n), .i_cs_n(cs_n),
    .i_rd_n(rd_n), .i_reg_sel(sel), .i_data(wd), .o_data(dout), .o_data_oe_n(doe), .i_pin(lvl),
    .o_pin(pin), .o_pin_oe_n(oe_n), .i_terminal_ready_out_a(tra), .i_terminal_ready_out_b(trb),
    .o_chain_order(chain), .o_rst_serial_unit(rs_s), .o_rst_counter_timer_unit(rs_t),
    .o_rst_parallel_port_unit(rs_p), .o_serial_signal_route_flag(route), .o_irq_n(irq));
  bpcl_pin_model bpcl_pin_model_i (.i_drv(pin), .i_oe_n(oe_n), .i_ext(ext), .o_lvl(lvl));
  initial forever #12.5 clk = ~clk;
  // Records the last unit reset pattern and how many cycles such pulses stand
  always @(negedge clk)
  begin
    if ({rs_p, rs_t, rs_s} != 3'h0)
    begin
      useen = {rs_p, rs_t, rs_s};
      n_pulse++;
    end
  end
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  // One whole bus cycle; strobes held well past the action edge
  task automatic cyc(input logic r, input logic [1:0] s, input logic [7:0] d);
    @(posedge clk);
    #2 {io_n, cs_n, rd_n, sel, wd} = {2'b00, !r, s, d};
    repeat (6) @(posedge clk);
    #2 q = dout;
    qoe = doe;
    {io_n, cs_n, rd_n} = 3'b111;
    chk("bus drive", {7'h0, !r}, {7'h0, qoe});
    repeat (5) @(posedge clk);
    #2 chk("bus released", 8'h01, {7'h0, doe});
  endtask
  task automatic summarize;
    $display("checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #50us;
    n_errors++;
    $display("timeout");
    summarize();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    #2 rst = 0;
    chk("direction", 8'hff, oe_n);
    chk("irq", 8'h01, {7'h0, irq});
    chk("route reset", 8'h00, {7'h0, route});
    cyc(1, 2'h2, 8'h00);
    chk("command read", 8'h00, q);
    cyc(1, 2'h0, 8'h00);
    chk("port input", 8'h5a, q);
    $display("reset test done");
    cyc(0, 2'h1, 8'h0f);
    cyc(0, 2'h0, 8'h3c);
    chk("enables", 8'h0f, oe_n);
    chk("pin out", 8'h30, pin & 8'hf0);
    cyc(1, 2'h0, 8'h00);
    chk("port mixed", 8'h3a, q);
    #2 ext = 8'ha5;
    cyc(1, 2'h0, 8'h00);
    chk("port mixed new", 8'h35, q);
    cyc(0, 2'h3, 8'hff);
    cyc(1, 2'h3, 8'h00);
    chk("unmapped", 8'h00, q);
    chk("enables kept", 8'h0f, oe_n);
    $display("port test done");
    for (int c = 0; c < 8; c++)
    begin
      cyc(0, 2'h2, {5'h01, c[2:0]});
      chk("chain", {5'h0, c[2:0]}, {5'h0, chain});
    end
    for (int u = 0; u < 8; u++)
    begin
      cyc(0, 2'h2, {1'b0, u[2:0], 4'h0});
      chk("unit reset", {5'h0, u[2:0]}, {5'h0, useen});
    end
    chk("unit pulse cycles", 8'h07, 8'(n_pulse));
    cyc(1, 2'h2, 8'h00);
    chk("chain kept", 8'h07, q);
    $display("command test done");
    #2 {tra, trb} = 2'b10;
    cyc(0, 2'h2, 8'h80);
    chk("route flag", 8'h01, {7'h0, route});
    chk("ready pins", 8'h08, {4'h0, pin[5], pin[2], oe_n[5], oe_n[2]});
    #2 {tra, trb} = 2'b01;
    repeat (5) @(posedge clk);
    #2 chk("ready pins swap", 8'h04, {4'h0, pin[5], pin[2], oe_n[5], oe_n[2]});
    cyc(1, 2'h2, 8'h00);
    chk("route read", 8'h87, q);
    cyc(0, 2'h2, 8'h00);
    chk("port back", 8'h0f, oe_n);
    chk("route cleared", 8'h00, {7'h0, route});
    $display("route test done");
    summarize();
  end
endmodule
